//--- logic/adc_host_pkg.sv
// package of timing counts, widths and states for the converter host controller
package adc_host_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESULT_W = 10;
  localparam int MSB_W = 6;
  localparam int LSB_W = 4;
  // minimum sample strobe low time, separate-strobe mode
  localparam int SAMPLE_MIN_NS = 250;
  localparam int SAMPLE_CYC = (SAMPLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // worst-case conversion times
  localparam int CONV_SEP_MAX_NS = 1800;
  localparam int CONV_TIED_MAX_NS = 2400;
  localparam int CONV_SEP_CYC = CONV_SEP_MAX_NS / CLK_PERIOD_NS;
  localparam int CONV_TIED_CYC = CONV_TIED_MAX_NS / CLK_PERIOD_NS;
  // data valid after completion flag falls, tied-strobe mode
  localparam int DATA_VALID_NS = 20;
  localparam int DATA_VALID_CYC = (DATA_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // flag release / bus release after read strobe rises
  localparam int RELEASE_NS = 50;
  localparam int RELEASE_CYC = (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // recovery before next conversion
  localparam int RECOVER_NS = 20;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // extra cycles allowed past worst case before timeout
  localparam int TIMEOUT_SLACK_CYC = 4;
  localparam int CNT_W = 8;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;

  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_SAMPLE  = 7'h02,
    ST_CONVERT = 7'h04,
    ST_SETTLE  = 7'h08,
    ST_READ    = 7'h10,
    ST_RELEASE = 7'h20,
    ST_RECOVER = 7'h40
  } host_state_e;
endpackage : adc_host_pkg

//--- logic/cycle_timer.sv
// down-counting cycle timer with load and done flag
`timescale 1ns/10ps
module cycle_timer #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic load_in,
  input wire logic [WIDTH-1:0] count_in,
  output logic done_out
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic done;
  } timer_s;
  timer_s cur;
  timer_s next_cur;

  // load restarts, otherwise count down to zero
  always_comb begin
    next_cur = cur;
    if (load_in) begin
      next_cur.cnt = count_in;
      next_cur.done = 1'b0;
    end else if (cur.cnt != '0) begin
      next_cur.cnt = cur.cnt - 1'b1;
      next_cur.done = (cur.cnt == {{(WIDTH-1){1'b0}}, 1'b1});
    end else begin
      next_cur.done = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign done_out = cur.done;
endmodule : cycle_timer

//--- logic/adc_host_ctrl.sv
// host controller that starts conversions on the half-flash converter and reads results
//
// Operation
// RL1: device builds 10-bit result: six upper bits, then four lower bits.
// RL2: device coarse estimator picks upper-ladder taps before first flash.
// RL3: device tap window spans one sixteenth beyond estimate, correcting estimator error.
// RL4: device reuses sixteen comparators for second flash on lower ladder.
// RL5: device decodes second flash and latches combined 10-bit result.
// RL6: host holds sample strobe low at least 250 ns in separate mode.
// RL7: device comparators track input while gated sample strobe low.
// RL8: device latches coarse result and starts fine step on strobe rise.
// RL9: completion flag falls within 1.8 us of sample strobe rise.
// RL10: chip select gates sample and read strobes; host drives select low.
// RL11: tied mode: host pulls the combined strobe low to start.
// RL12: tied mode: device samples on falling strobe, internal timer sequences.
// RL13: tied mode: completion flag falls within 2.4 us of strobe fall.
// RL14: tied mode: result bus valid about 20 ns after flag falls.
// RL15: tied mode: bus changes during conversion; host trusts it after flag.
// RL16: completion flag returns high within 50 ns of read strobe rise.
// RL17: data outputs go high impedance within 50 ns of read rise.
// RL18: device ready for next conversion within 20 ns of previous end.
// RL19: data outputs driven only while select and read strobe both low.
`timescale 1ns/10ps
module adc_host_ctrl
  import adc_host_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC,
  parameter int CONV_SEP_CYCLES = CONV_SEP_CYC,
  parameter int CONV_TIED_CYCLES = CONV_TIED_CYC
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic start_in,
  input wire logic tied_mode_in,
  input wire logic done_n_in,
  input wire logic [RESULT_W-1:0] result_bus_in,
  output logic select_n_out,
  output logic sample_n_out,
  output logic read_n_out,
  output logic busy_out,
  output logic result_valid_out,
  output logic timeout_out,
  output logic [RESULT_W-1:0] result_out
);
  typedef struct packed {
    host_state_e state;
    logic tied;
    logic armed;
    logic select_n;
    logic sample_n;
    logic read_n;
    logic busy;
    logic result_valid;
    logic timeout;
    logic [RESULT_W-1:0] result;
  } host_s;

  // registered state and its next value
  host_s cur;
  host_s next_cur;
  // handshake with the shared timer
  logic timer_load;
  logic [CNT_W-1:0] timer_count;
  logic timer_done;

  ////////////////////////////////////////////////////////////////////////////
  // timer loads, cut to the counter width once here
  localparam logic [CNT_W-1:0] LOAD_SAMPLE = CNT_W'(SAMPLE_CYCLES);
  localparam logic [CNT_W-1:0] LOAD_SEP = CNT_W'(CONV_SEP_CYCLES + TIMEOUT_SLACK_CYC);
  localparam logic [CNT_W-1:0] LOAD_TIED = CNT_W'(CONV_TIED_CYCLES + TIMEOUT_SLACK_CYC);
  localparam logic [CNT_W-1:0] LOAD_SETTLE = CNT_W'(DATA_VALID_CYC);
  localparam logic [CNT_W-1:0] LOAD_RELEASE = CNT_W'(RELEASE_CYC);
  localparam logic [CNT_W-1:0] LOAD_RECOVER = CNT_W'(RECOVER_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // shared cycle timer for strobe widths and conversion timeouts
  cycle_timer #(
    .WIDTH(CNT_W)
  ) u_timer (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .load_in(timer_load),
    .count_in(timer_count),
    .done_out(timer_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencing of strobes
  always_comb begin
    next_cur = cur;
    // pulses and timer strobes default low
    next_cur.result_valid = 1'b0;
    timer_load = 1'b0;
    timer_count = '0;
    case (cur.state)
      ST_IDLE: begin
        // a start is only taken here; later ones are ignored until the return to ST_IDLE
        if (start_in) begin
          next_cur.tied = tied_mode_in;
          next_cur.armed = 1'b0;
          next_cur.busy = 1'b1;
          next_cur.timeout = 1'b0;
          next_cur.select_n = 1'b0; // select gates strobes [RL10]
          next_cur.sample_n = 1'b0; // strobe low starts sampling [RL6] [RL11]
          timer_load = 1'b1;
          if (tied_mode_in) begin
            // combined strobe: read falls with sample [RL11] [RL12]
            next_cur.read_n = 1'b0;
            timer_count = LOAD_TIED; // [RL13]
            next_cur.state = ST_CONVERT;
          end else begin
            timer_count = LOAD_SAMPLE; // [RL6]
            next_cur.state = ST_SAMPLE;
          end
        end
      end

      ST_SAMPLE: begin
        // hold sample low for the minimum tracking time [RL6] [RL7]
        if (timer_done) begin
          next_cur.sample_n = 1'b1; // rising edge latches coarse step [RL8]
          timer_load = 1'b1;
          timer_count = LOAD_SEP; // [RL9]
          next_cur.state = ST_CONVERT;
        end
      end

      ST_CONVERT: begin
        // a flag still low from an earlier conversion is not taken
        if (done_n_in) begin
          next_cur.armed = 1'b1;
        end
        // wait for completion flag; bus contents ignored until then [RL15]
        if (!done_n_in && cur.armed) begin
          next_cur.read_n = 1'b0;
          timer_load = 1'b1;
          timer_count = LOAD_SETTLE; // [RL14]
          next_cur.state = ST_SETTLE;
        end else if (timer_done) begin
          // give up: strobes and select high
          next_cur.timeout = 1'b1; // flag missed its worst-case time [RL9] [RL13]
          next_cur.sample_n = 1'b1;
          next_cur.read_n = 1'b1;
          next_cur.select_n = 1'b1;
          timer_load = 1'b1;
          timer_count = LOAD_RECOVER;
          next_cur.state = ST_RECOVER;
        end
      end

      ST_SETTLE: begin
        // allow access time before capturing data [RL14]
        if (timer_done) begin
          next_cur.state = ST_READ;
        end
      end

      ST_READ: begin
        // capture the latched 10-bit result [RL1] [RL5]
        next_cur.result = result_bus_in;
        next_cur.result_valid = 1'b1;
        next_cur.read_n = 1'b1;
        next_cur.sample_n = 1'b1;
        timer_load = 1'b1;
        timer_count = LOAD_RELEASE; // [RL16] [RL17]
        next_cur.state = ST_RELEASE;
      end

      ST_RELEASE: begin
        // let flag rise and bus float before deselecting [RL16] [RL17] [RL19]
        if (timer_done) begin
          next_cur.select_n = 1'b1;
          timer_load = 1'b1;
          timer_count = LOAD_RECOVER; // [RL18]
          next_cur.state = ST_RECOVER;
        end
      end

      ST_RECOVER: begin
        // recovery gap before the next conversion [RL18]
        if (timer_done) begin
          next_cur.busy = 1'b0;
          next_cur.state = ST_IDLE;
        end
      end

      default: begin
        next_cur.state = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      // idle: strobes and select high, nothing captured
      cur.state <= ST_IDLE;
      cur.tied <= 1'b0;
      cur.armed <= 1'b0;
      cur.select_n <= 1'b1;
      cur.sample_n <= 1'b1;
      cur.read_n <= 1'b1;
      cur.busy <= 1'b0;
      cur.result_valid <= 1'b0;
      cur.timeout <= 1'b0;
      cur.result <= RESULT_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign select_n_out = cur.select_n;
  assign sample_n_out = cur.sample_n;
  assign read_n_out = cur.read_n;
  assign busy_out = cur.busy;
  assign result_valid_out = cur.result_valid;
  assign timeout_out = cur.timeout;
  assign result_out = cur.result;
endmodule : adc_host_ctrl

//--- verif/adc_host_props.sv
// assertions on the converter host controller ports
`timescale 1ns/10ps
module adc_host_props
  import adc_host_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic tied_mode_in,
  input wire logic done_n_in,
  input wire logic select_n_out,
  input wire logic sample_n_out,
  input wire logic read_n_out,
  input wire logic result_valid_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  // strobe steps of one conversion
  sequence sep_start; $fell(sample_n_out) && read_n_out; endsequence
  sequence flag_seen; !$past(done_n_in); endsequence
  AST_SAMPLE_MIN: assert property (sep_start |-> !sample_n_out[*3])
    else $error("sample strobe low too short");
  AST_SELECT_GATES: assert property ((!sample_n_out || !read_n_out) |-> !select_n_out)
    else $error("strobe without chip select");
  AST_TIED_JOINT: assert property ($fell(sample_n_out) |-> read_n_out == !tied_mode_in)
    else $error("strobes not joined as mode asks");
  AST_READ_AFTER_FLAG: assert property (($fell(read_n_out) && sample_n_out) |-> flag_seen)
    else $error("read before completion flag");
  AST_VALID_AFTER_FLAG: assert property (result_valid_out |-> flag_seen)
    else $error("result taken before completion flag");
endmodule : adc_host_props
bind adc_host_ctrl adc_host_props u_props (.*);

//--- verif/adc_dev_model.sv
// behavioural model of the half-flash converter pins
`timescale 1ns/10ps
module adc_dev_model
  import adc_host_pkg::*;
(
  input wire logic select_n_in,
  input wire logic sample_n_in,
  input wire logic read_n_in,
  input wire logic slow_in,
  input wire logic mute_in,
  input wire logic [RESULT_W-1:0] value_in,
  output logic done_n_out,
  output logic [RESULT_W-1:0] result_bus_out
);
  logic [RESULT_W-1:0] held = '0;
  logic flag_n = 1'b1;
  logic ready = 1'b0;
  logic churn = 1'b0;
  logic conv = 1'b0;
  always #30 churn = ~churn;
  // conversion timing per strobe mode
  always @(negedge sample_n_in) begin
    #1;
    if (!select_n_in && !conv) begin
      conv = 1'b1;
      if (read_n_in) begin
        @(posedge sample_n_in);
        #1;
        #(slow_in ? 1800 : 1200);
      end else begin
        #(slow_in ? 2400 : 1800);
      end
      held = {value_in[RESULT_W-1:LSB_W], value_in[LSB_W-1:0]};
      conv = 1'b0;
      if (!mute_in) begin
        flag_n = 1'b0;
        #20 ready = 1'b1;
      end
    end
  end
  // flag release after read
  always @(posedge read_n_in) begin
    #10 flag_n = 1'b1;
    ready = 1'b0;
  end
  assign done_n_out = flag_n;
  // released bus shows inverse, churns until valid
  assign result_bus_out = (select_n_in || read_n_in) ? ~held
    : (ready ? held : {RESULT_W{churn}});
endmodule : adc_dev_model

//--- verif/tb.sv
// self-checking bench for the converter host controller
`timescale 1ns/10ps
module tb;
  import adc_host_pkg::*;
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic start_in = 1'b0;
  logic tied_mode_in = 1'b0;
  logic slow = 1'b0;
  logic mute = 1'b0;
  logic [RESULT_W-1:0] value = '0;
  logic done_n, sel_n, smp_n, rd_n, busy, valid, tmo;
  logic [RESULT_W-1:0] bus, result;
  int fails = 0;
  int comparisons = 0;
  always #50 core_clk_in = ~core_clk_in;
  adc_host_ctrl u_dut (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .start_in(start_in), .tied_mode_in(tied_mode_in), .done_n_in(done_n),
    .result_bus_in(bus), .select_n_out(sel_n), .sample_n_out(smp_n), .read_n_out(rd_n),
    .busy_out(busy), .result_valid_out(valid), .timeout_out(tmo), .result_out(result));
  adc_dev_model u_dev (.select_n_in(sel_n), .sample_n_in(smp_n), .read_n_in(rd_n),
    .slow_in(slow), .mute_in(mute), .value_in(value), .done_n_out(done_n),
    .result_bus_out(bus));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  // one conversion started at the idle edge, judged at its end
  task automatic convert(input logic tied, input logic [RESULT_W-1:0] v);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 60) begin
      @(negedge core_clk_in);
      n++;
    end
    value = v;
    tied_mode_in = tied;
    start_in = 1'b1;
    @(negedge core_clk_in);
    start_in = 1'b0;
    while (valid !== 1'b1 && busy !== 1'b0 && n < 90) begin
      @(negedge core_clk_in);
      n++;
    end
    check({tmo, valid}, {mute, !mute});
    if (!mute) check(result, v);
  endtask : convert
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    check({sel_n, smp_n, rd_n, busy, valid, tmo}, 6'h38);
    check(result, RESULT_RESET);
  endtask : test_reset
  task automatic test_modes();
    int i;
    for (i = 0; i < 4; i++) begin
      slow = i[0];
      convert(i[1], 10'h2A5);
      convert(i[1], i[0] ? 10'h3FF : 10'h000);
    end
  endtask : test_modes
  task automatic test_timeout();
    mute = 1'b1;
    convert(1'b0, 10'h155);
    convert(1'b1, 10'h0AA);
    mute = 1'b0;
    convert(1'b1, 10'h1C3);
  endtask : test_timeout
  // main sequence
  initial begin
    repeat (12) @(negedge core_clk_in);
    test_reset();
    sys_rst_in = 1'b0;
    test_modes();
    test_timeout();
    final_report();
  end
  // watchdog
  initial begin
    #80000;
    fails++;
    final_report();
  end
endmodule : tb
